// >>> shared/cmdb_defs.svh
// constants of the configurable registered command buffer
// assumes inclusion by bare name from package and design files
`ifndef CMDB_DEFS_SVH
`define CMDB_DEFS_SVH

// -----------------------------------------------------------------
// widths
// -----------------------------------------------------------------
`define CMDB_DATA_W 25
`define CMDB_LANE_W 28

// -----------------------------------------------------------------
// field positions inside a packed output lane
// -----------------------------------------------------------------
`define CMDB_CKE_BIT 25
`define CMDB_ODT_BIT 26
`define CMDB_CS_BIT 27

// -----------------------------------------------------------------
// data lanes live per mode, bit n-1 is input number n
// -----------------------------------------------------------------
`define CMDB_MASK_1TO1 25'h1ffffb6
`define CMDB_MASK_A 25'h0003fb6
`define CMDB_MASK_B 25'h0001bbf

// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define CMDB_LANE_RST 28'h0000000
`define CMDB_DATA_ZERO 25'h0000000
`define CMDB_RX_RST 1'h0

`endif

// >>> shared/cmdb_pkg.sv
// types of the configurable registered command buffer
// assumes cmdb_defs.svh on the include path
`include "cmdb_defs.svh"

package cmdb_pkg;

  // -----------------------------------------------------------------
  // fan-out modes, one-hot
  // -----------------------------------------------------------------
  typedef enum logic [2:0]
  {
    CMDB_MODE_1TO1 = 3'h1,
    CMDB_MODE_A = 3'h2,
    CMDB_MODE_B = 3'h4
  } cmdb_mode_t;

  typedef logic [`CMDB_DATA_W-1:0] cmdb_data_t;
  typedef logic [`CMDB_LANE_W-1:0] cmdb_lane_t;

endpackage

// >>> logic/cmdb_lane_reg.sv
// output register stage with asynchronous clear and load enable
// assumes a single clock; load already includes the clock enable
`timescale 1ns/1ps
`default_nettype none
`include "cmdb_defs.svh"

module cmdb_lane_reg
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic load,
  input wire cmdb_pkg::cmdb_lane_t d,
  output cmdb_pkg::cmdb_lane_t q
);

  import cmdb_pkg::*;

  cmdb_lane_t q_r;
  cmdb_lane_t q_nxt;

  always_comb
  begin
    q_nxt = q_r;
    if (load)
    begin
      q_nxt = d;
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      q_r <= `CMDB_LANE_RST;
    end
    else
    begin
      q_r <= q_nxt;
    end
  end

  assign q = q_r;

endmodule
`default_nettype wire

// >>> logic/cmdb_top.sv
// configurable registered command buffer, 22 bits 1:1 or 11 bits 1:2
// assumes core_clk stands for the true/complement clock crossing
`timescale 1ns/1ps
`default_nettype none
`include "cmdb_defs.svh"

module cmdb_top
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic pinout_select,
  input wire logic width_select,
  input wire logic device_chip_select_n,
  input wire logic rank_chip_select_n,
  input wire logic clock_enable_in,
  input wire logic termination_in,
  input wire cmdb_pkg::cmdb_data_t data_in,
  output cmdb_pkg::cmdb_data_t data_out_a,
  output cmdb_pkg::cmdb_data_t data_out_b,
  output logic clock_enable_out_a,
  output logic clock_enable_out_b,
  output logic termination_out_a,
  output logic termination_out_b,
  output logic chip_select_out_a,
  output logic chip_select_out_b,
  output logic rx_enabled
);

  import cmdb_pkg::*;

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  function automatic cmdb_data_t mode_mask(input cmdb_mode_t m);
    cmdb_data_t r;
    r = `CMDB_DATA_ZERO;
    case (m)
      CMDB_MODE_1TO1: r = `CMDB_MASK_1TO1;
      CMDB_MODE_A: r = `CMDB_MASK_A;
      CMDB_MODE_B: r = `CMDB_MASK_B;
      default: r = `CMDB_DATA_ZERO;
    endcase
    return r;
  endfunction

  function automatic cmdb_lane_t pack_lane(input cmdb_data_t d, input logic cke,
                                           input logic odt, input logic cs);
    cmdb_lane_t r;
    r = `CMDB_LANE_RST;
    r[`CMDB_DATA_W-1:0] = d;
    r[`CMDB_CKE_BIT] = cke;
    r[`CMDB_ODT_BIT] = odt;
    r[`CMDB_CS_BIT] = cs;
    return r;
  endfunction

  // -----------------------------------------------------------------
  // mode decode
  // -----------------------------------------------------------------
  cmdb_mode_t mode;

  always_comb
  begin
    if (!width_select)
    begin
      mode = CMDB_MODE_1TO1;
    end
    else if (!pinout_select)
    begin
      mode = CMDB_MODE_A;
    end
    else
    begin
      mode = CMDB_MODE_B;
    end
  end

  // -----------------------------------------------------------------
  // receiver enable
  // -----------------------------------------------------------------
  logic rx_on_r;
  logic rx_on_nxt;

  always_comb
  begin
    rx_on_nxt = rx_on_r;
    if (clk_en)
    begin
      rx_on_nxt = 1'h1;
    end
  end

  // receivers come up on the first edge with clk_en high after reset release
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_on_r <= `CMDB_RX_RST;
    end
    else
    begin
      rx_on_r <= rx_on_nxt;
    end
  end

  assign rx_enabled = rx_on_r;

  // -----------------------------------------------------------------
  // input steering
  // -----------------------------------------------------------------
  logic gate;
  logic load;
  cmdb_data_t d_rx;
  logic cke_rx;
  logic odt_rx;
  logic cs_rx;
  cmdb_lane_t next_a;
  cmdb_lane_t next_b;

  always_comb
  begin
    // disabled receivers read as low
    d_rx = rx_on_r ? data_in : `CMDB_DATA_ZERO;
    cke_rx = rx_on_r & clock_enable_in;
    odt_rx = rx_on_r & termination_in;
    cs_rx = rx_on_r ? device_chip_select_n : 1'h0;
    gate = device_chip_select_n & rank_chip_select_n;
    load = clk_en & ~gate;
    next_a = pack_lane(d_rx & mode_mask(mode), cke_rx, odt_rx, cs_rx);
    next_b = `CMDB_LANE_RST;
    if (mode != CMDB_MODE_1TO1)
    begin
      next_b = next_a;
    end
  end

  // -----------------------------------------------------------------
  // output registers, single flop stage from input to pin
  // -----------------------------------------------------------------
  cmdb_lane_t q_a;
  cmdb_lane_t q_b;

  cmdb_lane_reg u_reg_a (
    .core_clk(core_clk),
    .resetn(resetn),
    .load(load),
    .d(next_a),
    .q(q_a)
  );

  cmdb_lane_reg u_reg_b (
    .core_clk(core_clk),
    .resetn(resetn),
    .load(load),
    .d(next_b),
    .q(q_b)
  );

  assign data_out_a = q_a[`CMDB_DATA_W-1:0];
  assign data_out_b = q_b[`CMDB_DATA_W-1:0];
  assign clock_enable_out_a = q_a[`CMDB_CKE_BIT];
  assign clock_enable_out_b = q_b[`CMDB_CKE_BIT];
  assign termination_out_a = q_a[`CMDB_ODT_BIT];
  assign termination_out_b = q_b[`CMDB_ODT_BIT];
  assign chip_select_out_a = q_a[`CMDB_CS_BIT];
  assign chip_select_out_b = q_b[`CMDB_CS_BIT];

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  reset_low_a: assert property (
    @(posedge core_clk) !resetn |-> (q_a == `CMDB_LANE_RST && q_b == `CMDB_LANE_RST))
    else $error("outputs not low during reset");

  reset_prio_a: assert property (
    @(posedge core_clk) (!resetn && !(device_chip_select_n && rank_chip_select_n))
      |-> (q_a == `CMDB_LANE_RST && !rx_on_r))
    else $error("chip select overrode reset");

  rx_gate_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (!rx_on_r) |=> (q_a == `CMDB_LANE_RST && q_b == `CMDB_LANE_RST) || $stable(q_a))
    else $error("disabled receivers reached outputs");

  release_low_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    ($rose(rx_on_r) && data_in == `CMDB_DATA_ZERO && !clock_enable_in && !termination_in
      && !device_chip_select_n) |=> (q_a == `CMDB_LANE_RST) [*2])
    else $error("glitch after reset release");

  capture_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (clk_en && !gate) |=> (q_a == $past(next_a) && q_b == $past(next_b)))
    else $error("inputs not captured");

  gate_hold_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (device_chip_select_n && rank_chip_select_n) |=> ($stable(q_a) && $stable(q_b)))
    else $error("outputs changed while gated");

  gate_keep_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (gate && clk_en) [*3] |=> (q_a == $past(q_a, 3)))
    else $error("gated value lost");

  normal_upd_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (clk_en && rx_on_r && !rank_chip_select_n)
      |=> (data_out_a == $past(data_in & mode_mask(mode))))
    else $error("ungated update missed");

  one_to_one_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (load && !width_select && rx_on_r) |=> (data_out_b == `CMDB_DATA_ZERO
      && clock_enable_out_a == $past(clock_enable_in) && chip_select_out_b == 1'h0))
    else $error("one-to-one mapping wrong");

  width_sel_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (load && width_select) |=> ((data_out_a & ~`CMDB_MASK_B & ~`CMDB_MASK_A)
      == `CMDB_DATA_ZERO))
    else $error("wide lane driven in two-output mode");

  pinout_sel_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (load && width_select && pinout_select) |=> ((data_out_a & ~`CMDB_MASK_B)
      == `CMDB_DATA_ZERO))
    else $error("pinout B lanes wrong");

  pair_equal_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (load && width_select) |=> (q_a == q_b))
    else $error("A and B outputs differ");

  reset_gate_a: assert property (
    @(posedge core_clk) (!resetn && device_chip_select_n && rank_chip_select_n)
      |-> (q_a == `CMDB_LANE_RST && q_b == `CMDB_LANE_RST && !rx_on_r))
    else $error("gating held outputs through reset");

  dev_sel_upd_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (clk_en && rx_on_r && !device_chip_select_n)
      |=> (chip_select_out_a == 1'h0 && data_out_a == $past(data_in & mode_mask(mode))))
    else $error("select low did not update outputs");

  direct_map_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (load && !width_select && rx_on_r) |=> (data_out_a == $past(data_in & `CMDB_MASK_1TO1)
      && termination_out_a == $past(termination_in)
      && chip_select_out_a == $past(device_chip_select_n)))
    else $error("one-to-one lane lost");

  side_b_idle_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (load && !width_select) |=> (q_b == `CMDB_LANE_RST))
    else $error("second outputs driven in one-to-one mode");

  ctrl_pair_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (load && width_select && rx_on_r) |=> (clock_enable_out_b == $past(clock_enable_in)
      && termination_out_b == $past(termination_in)
      && chip_select_out_b == $past(device_chip_select_n)))
    else $error("second control outputs wrong");

  pinout_low_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (load && width_select && !pinout_select) |=> ((data_out_a & ~`CMDB_MASK_A)
      == `CMDB_DATA_ZERO))
    else $error("pinout A lanes wrong");

  rx_stay_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    rx_on_r |=> rx_on_r)
    else $error("receivers dropped without reset");

  // sampled resetn keeps the release edge itself out
  rx_up_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (resetn && !rx_on_r && clk_en)
      |=> (rx_on_r && q_a == `CMDB_LANE_RST && q_b == `CMDB_LANE_RST))
    else $error("receivers not up after release");

  en_freeze_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    !clk_en |=> ($stable(q_a) && $stable(q_b) && $stable(rx_on_r)))
    else $error("state moved with clock enable low");

endmodule
`default_nettype wire

// >>> sim/cmdb_ctrl_model.sv
// controller model driving the command buffer inputs
// assumes the bench raises run only after receivers are up
`timescale 1ns/1ps
`default_nettype none

module cmdb_ctrl_model
(
  input wire logic core_clk,
  input wire logic run,
  input wire logic gate,
  input wire logic tie_rank,
  output cmdb_pkg::cmdb_data_t data_in,
  output logic clock_enable_in,
  output logic termination_in,
  output logic device_chip_select_n,
  output logic rank_chip_select_n
);

  import cmdb_pkg::*;

  // -----------------------------------------
  // random commands, all low while idle except the two selects, which follow gate
  // -----------------------------------------
  // pins float until the first edge, inside reset
  always @(posedge core_clk)
  begin
    data_in <= run ? cmdb_data_t'($urandom) : 25'h0;
    clock_enable_in <= run & 1'($urandom);
    termination_in <= run & 1'($urandom);
    device_chip_select_n <= gate | (run & 1'($urandom));
    rank_chip_select_n <= gate | (run & ~tie_rank & 1'($urandom));
  end
endmodule

`default_nettype wire

// >>> sim/configurable_registered_cmd_buffer_test.sv
// self-checking bench of the command buffer against a queue-free model
// assumes cmdb_defs.svh on the include path and cmdb_top as the design
`timescale 1ns/1ps
`default_nettype none
`include "cmdb_defs.svh"

`define CHK(nm, e, g) \
  begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end

module configurable_registered_cmd_buffer_test;
  import cmdb_pkg::*;
  logic core_clk, resetn, clk_en, pinout_select, width_select, run, gate, tie_rank;
  logic cke, odt, dcs_n, rcs_n, rx_enabled;
  cmdb_data_t data_in, data_out_a, data_out_b, m_a, m_b, msk;
  logic [5:0] m_c;
  wire logic [5:0] got_c;
  logic m_rx;
  int n_mismatch, n_tests, seed;

  cmdb_ctrl_model i_cmdb_ctrl_model (.core_clk(core_clk), .run(run), .gate(gate),
    .tie_rank(tie_rank), .data_in(data_in), .clock_enable_in(cke), .termination_in(odt),
    .device_chip_select_n(dcs_n), .rank_chip_select_n(rcs_n));

  cmdb_top i_cmdb_top (.core_clk(core_clk), .resetn(resetn), .clk_en(clk_en),
    .pinout_select(pinout_select), .width_select(width_select),
    .device_chip_select_n(dcs_n), .rank_chip_select_n(rcs_n), .clock_enable_in(cke),
    .termination_in(odt), .data_in(data_in), .data_out_a(data_out_a),
    .data_out_b(data_out_b), .clock_enable_out_a(got_c[5]), .termination_out_a(got_c[4]),
    .chip_select_out_a(got_c[3]), .clock_enable_out_b(got_c[2]),
    .termination_out_b(got_c[1]), .chip_select_out_b(got_c[0]), .rx_enabled(rx_enabled));

  // -----------------------------------------
  // reference model
  // -----------------------------------------
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      {m_a, m_b, m_c, m_rx} = 57'h0;
    end
    else if (clk_en)
    begin
      if (!m_rx)
        m_rx = 1'h1;
      else if (!(dcs_n && rcs_n))
      begin
        msk = !width_select ? `CMDB_MASK_1TO1 : (pinout_select ? `CMDB_MASK_B : `CMDB_MASK_A);
        m_a = data_in & msk;
        m_b = width_select ? m_a : 25'h0;
        m_c = {cke, odt, dcs_n, width_select ? {cke, odt, dcs_n} : 3'h0};
      end
    end
  end

  task automatic chk_all();
    `CHK("data_out_a", m_a, data_out_a)
    `CHK("data_out_b", m_b, data_out_b)
    `CHK("ctrl_out", m_c, got_c)
    `CHK("rx_enabled", m_rx, rx_enabled)
  endtask

  always @(negedge core_clk)
    chk_all();

  task automatic give_verdict();
    $display("mismatches %0d of %0d comparisons", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  always #20 core_clk = ~core_clk;

  // -----------------------------------------
  // main sequence
  // -----------------------------------------
  initial
  begin
    {core_clk, resetn, clk_en, pinout_select, width_select, run, gate, tie_rank} = 8'h40;
    n_mismatch = 0;
    n_tests = 0;
    seed = $urandom(32'hae1a);
    // definite falling edge for every reset process
    #1;
    resetn = 1'h0;
    repeat (10) @(posedge core_clk);
    resetn <= 1'h1;
    clk_en <= 1'h1;
    repeat (4) @(posedge core_clk);
    for (int m = 0; m < 5; m++)
    begin
      run <= 1'h1;
      width_select <= (m == 1 || m == 2);
      pinout_select <= (m == 2 || m == 4);
      tie_rank <= (m == 3);
      repeat (200)
      begin
        @(posedge core_clk);
        clk_en <= ($urandom % 8) != 0;
        gate <= ($urandom % 16) == 0;
      end
    end
    @(posedge core_clk);
    gate <= 1'h1;
    clk_en <= 1'h1;
    repeat (3) @(posedge core_clk);
    #5;
    resetn = 1'h0;
    #1;
    chk_all();
    @(posedge core_clk);
    run <= 1'h0;
    gate <= 1'h0;
    repeat (3) @(posedge core_clk);
    resetn <= 1'h1;
    repeat (4) @(posedge core_clk);
    run <= 1'h1;
    repeat (100) @(posedge core_clk);
    give_verdict();
  end
endmodule

`default_nettype wire
